// [rtl/gbi_pkg.sv]
// gbi_pkg: constants, pin bundle and state codes for the instrument bus port.
// assumes a 10 MHz ref_clk; bus lines are seen at pin level, low = asserted.
package gbi_pkg;

  // clock and handshake timing
  localparam int CLK_NS = 100;
  localparam int T_SETTLE_NS = 2000; // data set-up before the valid strobe
  localparam int SETTLE_CYC = (T_SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 5;

  // addressing
  localparam logic [4:0] ADDR_DEF = 5'h10; // factory address, also used for switch 31
  localparam logic [4:0] ADDR_NONE = 5'h1f; // unlisten / untalk / illegal address

  // command group codes (bits 6:5 of a command byte)
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;

  // universal and addressed commands (7-bit)
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;

  // fifo shape in the receive path
  localparam int RX_W = 9;
  localparam int RX_DEPTH = 4;

  // status byte bit that carries the service request flag
  localparam int STB_RQS = 6;

  // raw pin sample, one field per bus line plus the address switch
  typedef struct packed {
    logic [4:0] addr;
    logic srq;
    logic ren;
    logic ifc;
    logic atn;
    logic eoi;
    logic dav;
    logic nrfd;
    logic ndac;
    logic [7:0] data;
  } gbi_pins_s;

  typedef enum logic [1:0] {A_IDLE, A_RDY, A_ACC} gbi_acc_e;
  typedef enum logic [1:0] {T_IDLE, T_SET, T_DAV, T_END} gbi_src_e;

endpackage : gbi_pkg

// [rtl/gbi_port.sv]
// gbi_port: instrument bus port acting as talker, listener or controller.
// assumes open-drain transceivers outside: every *_o but data_o is fixed low, *_oe pulls the line.
`timescale 1ns/10ps

// small synchronous fifo, depth a power of two
module gbi_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if ((DEPTH < 2) || ((DEPTH & (DEPTH - 1)) != 0)) begin : g_bad_depth
    $error("gbi_fifo: DEPTH must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } gbi_fifo_s;

  gbi_fifo_s q, d;
  logic push, pop;

  // full and empty come straight from the count, so ready really drops
  assign in_ready = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // pointer and count update
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : gbi_fifo

module gbi_port
  import gbi_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe,
  input wire logic dav_i,
  output logic dav_o,
  output logic dav_oe,
  input wire logic nrfd_i,
  output logic nrfd_o,
  output logic nrfd_oe,
  input wire logic ndac_i,
  output logic ndac_o,
  output logic ndac_oe,
  input wire logic atn_i,
  output logic atn_o,
  output logic atn_oe,
  input wire logic eoi_i,
  output logic eoi_o,
  output logic eoi_oe,
  input wire logic srq_i,
  output logic srq_o,
  output logic srq_oe,
  input wire logic ren_i,
  output logic ren_o,
  output logic ren_oe,
  input wire logic ifc_i,
  output logic ifc_o,
  output logic ifc_oe,
  input wire logic [4:0] addr_sw_i,
  input wire logic ctl_mode_i,
  input wire logic ctl_atn_i,
  input wire logic ctl_ren_i,
  input wire logic ctl_ifc_i,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_eoi,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_eoi,
  input wire logic rx_ready,
  input wire logic srq_req_i,
  input wire logic [7:0] stb_i,
  input wire logic ppoll_en_i,
  input wire logic ppoll_sense_i,
  input wire logic [2:0] ppoll_line_i,
  output logic talk_o,
  output logic listen_o,
  output logic remote_o,
  output logic srq_seen_o,
  output logic dev_clear_o
);

  if (SETTLE_CYC < 1 || SETTLE_CYC >= (1 << CNT_W)) begin : g_bad_settle
    $error("gbi_port: settle count does not fit its counter");
  end

  typedef struct packed {
    gbi_pins_s s1; // first sync stage, read only by s2
    gbi_pins_s s2;
    gbi_acc_e ast;
    gbi_src_e tst;
    logic lstn;
    logic tlk;
    logic spoll;
    logic remote;
    logic rqs;
    logic req_prev;
    logic tsp; // byte in flight is a status byte
    logic teoi;
    logic [7:0] tbyte;
    logic [7:0] dout;
    logic [CNT_W-1:0] cnt;
    logic clr;
  } gbi_port_s;

  gbi_port_s q, d;
  gbi_pins_s raw;
  logic atn_as, eoi_as, dav_as, nrfd_as, ndac_as, ren_as, ifc_as;
  logic [4:0] my_addr;
  logic [6:0] cmd;
  logic acc_en, src_en, sp_send, ppoll_act, rx_push, rx_in_ready, cmd_take;

  // every bus line and the switch pass two flops before use
  assign raw = '{addr: addr_sw_i, srq: srq_i, ren: ren_i, ifc: ifc_i, atn: atn_i,
                 eoi: eoi_i, dav: dav_i, nrfd: nrfd_i, ndac: ndac_i, data: data_i};

  // lines are active low on the wire
  assign atn_as = ~q.s2.atn;
  assign eoi_as = ~q.s2.eoi;
  assign dav_as = ~q.s2.dav;
  assign nrfd_as = ~q.s2.nrfd;
  assign ndac_as = ~q.s2.ndac;
  assign ren_as = ~q.s2.ren;
  assign ifc_as = ~q.s2.ifc;
  assign cmd = ~q.s2.data[6:0];

  // switch value 31 is not a legal address, so fall back to the default
  assign my_addr = (q.s2.addr == ADDR_NONE) ? ADDR_DEF : q.s2.addr;

  // acceptor joins every command handshake, data only when addressed
  assign acc_en = atn_as | q.lstn;

  // talker drives only with attention off; in controller mode it sends commands
  assign src_en = ctl_mode_i ? (ctl_atn_i | (q.tlk & ~atn_as))
                             : (q.tlk & ~atn_as);
  assign sp_send = q.spoll & q.tlk & ~atn_as & ~ctl_mode_i;

  // parallel poll answer: one data line, only while attention and end-identify
  assign ppoll_act = atn_as & eoi_as & ppoll_en_i & ~ctl_mode_i
                     & (srq_req_i == ppoll_sense_i);

  assign rx_push = (q.ast == A_RDY) & dav_as & ~atn_as & q.lstn;
  assign cmd_take = (q.ast == A_RDY) & dav_as & atn_as;

  // open-drain lines: control levels fixed low, data_o carries the byte, the enable does the driving
  assign data_o = q.dout;
  assign dav_o = 1'b0;
  assign nrfd_o = 1'b0;
  assign ndac_o = 1'b0;
  assign atn_o = 1'b0;
  assign eoi_o = 1'b0;
  assign srq_o = 1'b0;
  assign ren_o = 1'b0;
  assign ifc_o = 1'b0;

  assign data_oe = ((q.tst != T_IDLE) & src_en) | ppoll_act;
  assign dav_oe = (q.tst == T_DAV) & src_en;
  // command bytes never carry end-identify: with attention it would read as a poll
  assign eoi_oe = (q.tst != T_IDLE) & src_en & q.teoi & ~atn_as & ~atn_oe;
  assign nrfd_oe = acc_en & (q.ast != A_RDY);
  assign ndac_oe = acc_en & (q.ast != A_ACC);
  assign srq_oe = q.rqs & ~ctl_mode_i;
  assign atn_oe = ctl_mode_i & ctl_atn_i;
  assign ren_oe = ctl_mode_i & ctl_ren_i;
  assign ifc_oe = ctl_mode_i & ctl_ifc_i;

  // a user byte is consumed only once every listener has accepted it
  assign tx_ready = (q.tst == T_DAV) & src_en & ~ndac_as & ~q.tsp;

  assign talk_o = q.tlk;
  assign listen_o = q.lstn;
  assign remote_o = q.remote;
  assign srq_seen_o = ~q.s2.srq;
  assign dev_clear_o = q.clr;

  // receive buffer: when full the acceptor keeps not-ready asserted for data bytes; commands under attention still pass
  gbi_fifo #(
    .W(RX_W),
    .DEPTH(RX_DEPTH)
  ) u_rx_fifo (
    .clk(ref_clk),
    .rst_n(reset_n),
    .in_valid(rx_push),
    .in_ready(rx_in_ready),
    .in_data({eoi_as, ~q.s2.data}),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data({rx_eoi, rx_data})
  );

  // next-state logic for sync, acceptor, source and addressing
  always_comb begin
    d = q;
    d.s1 = raw;
    d.s2 = q.s1;
    d.clr = 1'b0;
    d.req_prev = srq_req_i;

    // acceptor handshake
    unique case (q.ast)
      A_IDLE: begin
        if (acc_en && (atn_as || rx_in_ready)) begin
          d.ast = A_RDY;
        end
      end
      A_RDY: begin
        if (!acc_en || (!atn_as && !rx_in_ready)) begin
          d.ast = A_IDLE;
        end else if (dav_as) begin
          d.ast = A_ACC;
        end
      end
      A_ACC: begin
        if (!dav_as || !acc_en) begin
          d.ast = A_IDLE; // not-accepted reasserted before next byte
        end
      end
      default: d.ast = A_IDLE;
    endcase

    // command decode; addressing comes only from the active controller
    if (cmd_take) begin
      if (cmd[6:5] == GRP_LISTEN) begin
        if (cmd[4:0] == ADDR_NONE) begin
          d.lstn = 1'b0;
        end else if (cmd[4:0] == my_addr) begin
          d.lstn = 1'b1;
          d.remote = q.remote | ren_as;
        end
      end else if (cmd[6:5] == GRP_TALK) begin
        d.tlk = (cmd[4:0] == my_addr);
      end else if (cmd == CMD_GTL && q.lstn) begin
        d.remote = 1'b0;
      end else if (cmd == CMD_DCL || (cmd == CMD_SDC && q.lstn)) begin
        d.clr = 1'b1;
      end else if (cmd == CMD_SPE) begin
        d.spoll = 1'b1;
      end else if (cmd == CMD_SPD) begin
        d.spoll = 1'b0;
      end
    end

    // source handshake; losing src_en drops data and valid at once
    unique case (q.tst)
      T_IDLE: begin
        if (src_en && (sp_send || tx_valid)) begin
          d.tsp = sp_send;
          d.tbyte = sp_send ? {stb_i[7], q.rqs, stb_i[5:0]} : tx_data;
          d.teoi = ~sp_send & tx_eoi;
          d.cnt = CNT_W'(SETTLE_CYC - 1);
          d.tst = T_SET;
        end
      end
      T_SET: begin
        if (q.cnt != '0) begin
          d.cnt = q.cnt - 1'b1;
        end else if (!nrfd_as && ndac_as) begin
          d.tst = T_DAV;
        end
      end
      T_DAV: begin
        if (!ndac_as) begin
          d.tst = T_END;
        end
      end
      T_END: begin
        if (ndac_as) begin
          d.tst = T_IDLE;
        end
      end
    endcase
    if (!src_en) begin
      d.tst = T_IDLE;
    end
    d.dout = ppoll_act ? ~(8'h01 << ppoll_line_i) : ~d.tbyte;

    // service request: rising request sets, an accepted status byte clears
    if (q.tst == T_DAV && !ndac_as && q.tsp && src_en) begin
      d.rqs = 1'b0;
    end
    if (srq_req_i && !q.req_prev) begin
      d.rqs = 1'b1;
    end

    // remote lasts only while enable is held
    if (!ren_as) begin
      d.remote = 1'b0;
    end

    // interface clear returns talker, listener, serial poll and both handshakes to base state
    if (ifc_as) begin
      d.lstn = 1'b0;
      d.tlk = 1'b0;
      d.spoll = 1'b0;
      d.ast = A_IDLE;
      d.tst = T_IDLE;
    end
  end

  // single state register; lines reset to released level
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      q <= '0;
      q.s1 <= '1;
      q.s2 <= '1;
    end else begin
      q <= d;
    end
  end
endmodule : gbi_port

// [tb/gbi_port_properties.sv]
// gbi_port_properties: bus handshake and management checks on the port's pins.
// assumes it is bound to gbi_port; bus pins are low when asserted.
`timescale 1ns/10ps
module gbi_port_properties (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic dav_i,
  input wire logic nrfd_i,
  input wire logic ndac_i,
  input wire logic atn_i,
  input wire logic ifc_i,
  input wire logic ctl_mode_i,
  input wire logic data_oe,
  input wire logic dav_oe,
  input wire logic nrfd_oe,
  input wire logic ndac_oe,
  input wire logic eoi_oe,
  input wire logic tx_ready,
  input wire logic talk_o,
  input wire logic listen_o
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // source side: data settles first, strobe only into ready listeners
  a_dav_settled: assert property ($rose(dav_oe) |-> data_oe && $past(data_oe, 19))
    else $error("valid strobe without settled data");
  a_dav_ready: assert property ($rose(dav_oe) |-> $past(nrfd_i) && !$past(ndac_i))
    else $error("valid strobe while listeners busy");
  a_accept_drop: assert property (tx_ready |-> dav_oe && ndac_i ##1 !dav_oe)
    else $error("valid strobe kept after acceptance");
  // acceptor side: the pin lags by the synchroniser, so only one cycle back is tied
  a_accept_dav: assert property ($fell(ndac_oe) && nrfd_oe |-> !$past(dav_i))
    else $error("byte accepted without valid strobe");
  a_ready_order: assert property ($fell(nrfd_oe) && listen_o && atn_i && ifc_i |-> ndac_oe)
    else $error("ready released before accept flag");
  // management lines
  a_atn_quiets: assert property ((!atn_i && !ctl_mode_i) [*3] |-> !dav_oe && !eoi_oe)
    else $error("talker still driving under attention");
  a_eoi_talker: assert property (eoi_oe |-> data_oe && talk_o)
    else $error("end flag without a talker byte");
  a_ifc_clears: assert property (!ifc_i [*3] |-> ##[0:3] !talk_o && !listen_o)
    else $error("interface clear left a role set");
endmodule : gbi_port_properties

bind gbi_port gbi_port_properties u_props (.*);

// [tb/gbi_bus_model.sv]
// gbi_bus_model: controller and other instruments on the port's far side.
// assumes open-drain lines with pull-ups; an *_oe high pulls its line low.
`timescale 1ns/10ps
module gbi_bus_model (
  input wire logic ref_clk,
  input wire logic [7:0] data_o,
  input wire logic data_oe,
  input wire logic dav_oe,
  input wire logic nrfd_oe,
  input wire logic ndac_oe,
  input wire logic atn_oe,
  input wire logic eoi_oe,
  input wire logic srq_oe,
  input wire logic ren_oe,
  input wire logic ifc_oe,
  output logic [7:0] data_i,
  output logic dav_i,
  output logic nrfd_i,
  output logic ndac_i,
  output logic atn_i,
  output logic eoi_i,
  output logic srq_i,
  output logic ren_i,
  output logic ifc_i
);
  logic [7:0] m_byte = 8'h00;
  logic m_dav = 1'b0, m_nrfd = 1'b0, m_ndac = 1'b0, m_atn = 1'b0;
  logic m_eoi = 1'b0, m_ren = 1'b0, m_ifc = 1'b0, hang = 1'b0;

  // wired-or of all asserts; a released line rises to its pull-up
  assign data_i = ~(m_byte | (data_oe ? ~data_o : 8'h00));
  assign dav_i = ~(m_dav | dav_oe);
  assign nrfd_i = ~(m_nrfd | nrfd_oe);
  assign ndac_i = ~(m_ndac | ndac_oe);
  assign atn_i = ~(m_atn | atn_oe);
  assign eoi_i = ~(m_eoi | eoi_oe);
  assign srq_i = ~srq_oe;
  assign ren_i = ~(m_ren | ren_oe);
  assign ifc_i = ~(m_ifc | ifc_oe);

  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask : step

  // talker or controller source; a lost handshake sets hang instead of blocking
  task automatic send(input logic [7:0] b, input logic atn, input logic eoi);
    m_atn = atn;
    m_nrfd = 1'b0;
    m_ndac = 1'b0;
    for (int i = 0; i < 500 && !(nrfd_i && !ndac_i); i++) step();
    hang |= !(nrfd_i && !ndac_i);
    m_byte = b;
    m_eoi = eoi;
    repeat (3) step();
    m_dav = 1'b1;
    for (int i = 0; i < 500 && !ndac_i; i++) step();
    hang |= !ndac_i;
    m_dav = 1'b0;
    m_byte = 8'h00;
    m_eoi = 1'b0;
    step();
  endtask : send

  // listener; slow cycles of hold-off before each answer
  task automatic recv(output logic [7:0] b, output logic e, input int slow);
    m_atn = 1'b0;
    m_ndac = 1'b1;
    m_nrfd = 1'b1;
    repeat (slow) step();
    m_nrfd = 1'b0;
    for (int i = 0; i < 500 && dav_i; i++) step();
    hang |= dav_i;
    b = ~data_i;
    e = ~eoi_i;
    m_nrfd = 1'b1;
    repeat (slow) step();
    m_ndac = 1'b0;
    for (int i = 0; i < 500 && !dav_i; i++) step();
    hang |= !dav_i;
    m_ndac = 1'b1;
    step();
  endtask : recv
endmodule : gbi_bus_model

// [tb/gbi_port_tb_top.sv]
// gbi_port_tb_top: self-checking bench for the instrument bus port.
// assumes gbi_bus_model plays every other party on the bus.
`timescale 1ns/10ps
module gbi_port_tb_top
  import gbi_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] data_i, data_o, rx_data, got, tx_data = 8'h3c, stb_i = 8'h81;
  logic data_oe, dav_i, dav_o, dav_oe, nrfd_i, nrfd_o, nrfd_oe, ndac_i, ndac_o, ndac_oe;
  logic atn_i, atn_o, atn_oe, eoi_i, eoi_o, eoi_oe, srq_i, srq_o, srq_oe, got_eoi;
  logic ren_i, ren_o, ren_oe, ifc_i, ifc_o, ifc_oe, tx_ready, rx_valid, rx_eoi;
  logic talk_o, listen_o, remote_o, srq_seen_o, dev_clear_o;
  logic [4:0] addr_sw_i = 5'h1f; // switch 31 selects the factory address
  logic ctl_mode_i = 1'b0, ctl_atn_i = 1'b0, ctl_ren_i = 1'b0, ctl_ifc_i = 1'b0;
  logic tx_valid = 1'b0, tx_eoi = 1'b1, rx_ready = 1'b0, srq_req_i = 1'b0;
  logic ppoll_en_i = 1'b0, ppoll_sense_i = 1'b0;
  logic [2:0] ppoll_line_i = 3'h0;
  int fails = 0, checks = 0;

  gbi_port dut (.*);
  gbi_bus_model bm (.*);

  // 10 MHz reference clock
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask : step

  task automatic check(input string n, input logic [9:0] s, input logic [9:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  // a stuck bus handshake ends the run at the next guard call
  task automatic guard();
    check("bus wait", bm.hang, 1'b0);
    if (bm.hang) begin
      conclude();
    end
  endtask : guard

  // talker side: hold the byte until consumed, bounded
  task automatic talk_byte(input int slow);
    tx_valid = 1'b1;
    fork
      bm.recv(got, got_eoi, slow);
      begin
        for (int i = 0; i < 600 && !tx_ready; i++) step();
        check("tx taken", tx_ready, 1'b1);
        step();
        tx_valid = 1'b0;
      end
    join
  endtask : talk_byte

  task automatic s_reset();
    check("idle", {talk_o, listen_o, remote_o, data_oe, dav_oe, nrfd_oe, ndac_oe}, 7'h00);
    check("idle lines", {dav_o, nrfd_o, ndac_o, atn_o, eoi_o, srq_o, ren_o, ifc_o}, 8'h00);
    check("idle flags", {atn_oe, eoi_oe, srq_oe, ren_oe, ifc_oe, tx_ready, rx_valid}, 7'h00);
    check("idle events", {dev_clear_o, srq_seen_o}, 2'h0);
  endtask : s_reset

  // listen at the switch address, fill the fifo, drain it, drop remote
  task automatic s_listen();
    bm.m_ren = 1'b1;
    bm.send({1'b0, GRP_LISTEN, ADDR_DEF}, 1'b1, 1'b0);
    repeat (4) step();
    check("listen", {listen_o, talk_o, remote_o}, 3'h5);
    for (int i = 0; i < 4; i++) begin
      bm.send(8'hff >> i, 1'b0, i == 3);
    end
    repeat (5) step();
    check("fifo full", {nrfd_oe, rx_valid}, 2'h3);
    rx_ready = 1'b1;
    for (int i = 0; i < 4; i++) begin
      check("rx", {rx_valid, rx_eoi, rx_data}, {1'b1, i == 3, 8'hff >> i});
      step();
    end
    rx_ready = 1'b0;
    check("rx empty", rx_valid, 1'b0);
    bm.m_ren = 1'b0;
    repeat (6) step();
    check("local", remote_o, 1'b0);
    bm.send(8'h3f, 1'b1, 1'b0);
    guard();
  endtask : s_listen

  // talk to a slow listener, then be cut off by attention and resume
  task automatic s_talk();
    bm.send({1'b0, GRP_TALK, ADDR_DEF}, 1'b1, 1'b0);
    check("talk", {talk_o, listen_o}, 2'h2);
    talk_byte(30);
    check("talked", {got_eoi, got}, 9'h13c);
    tx_data = 8'h99;
    tx_eoi = 1'b0;
    tx_valid = 1'b1;
    repeat (3) step();
    bm.m_atn = 1'b1;
    repeat (4) step();
    check("atn quiet", {data_oe, dav_oe, eoi_oe}, 3'h0);
    bm.m_atn = 1'b0;
    talk_byte(0);
    check("resent", {got_eoi, got}, 9'h099);
    bm.m_ifc = 1'b1;
    repeat (4) step();
    bm.m_ifc = 1'b0;
    repeat (2) step();
    check("clear", {talk_o, listen_o}, 2'h0);
    guard();
  endtask : s_talk

  // service request answered by a serial poll
  task automatic s_poll();
    srq_req_i = 1'b1;
    repeat (4) step();
    check("srq", {srq_oe, srq_seen_o}, 2'h3);
    bm.send({1'b0, CMD_SPE}, 1'b1, 1'b0);
    bm.send({1'b0, GRP_TALK, ADDR_DEF}, 1'b1, 1'b0);
    bm.recv(got, got_eoi, 0);
    check("status", got, {stb_i[7], 1'b1, stb_i[5:0]});
    repeat (4) step();
    check("srq off", srq_oe, 1'b0);
    srq_req_i = 1'b0;
    bm.send({1'b0, CMD_SPD}, 1'b1, 1'b0);
    bm.send(8'h5f, 1'b1, 1'b0);
    // parallel poll: status matches sense, so line 5 is pulled
    ppoll_en_i = 1'b1;
    ppoll_line_i = 3'h5;
    bm.m_eoi = 1'b1;
    repeat (4) step();
    check("ppoll", {data_oe, data_i}, {1'b1, 8'hdf});
    ppoll_sense_i = 1'b1;
    step();
    check("ppoll off", data_oe, 1'b0);
    bm.m_eoi = 1'b0;
    ppoll_en_i = 1'b0;
    guard();
  endtask : s_poll

  // controller mode drives the management lines and sends one command byte
  task automatic s_ctl();
    ctl_mode_i = 1'b1;
    ctl_ren_i = 1'b1;
    ctl_ifc_i = 1'b1;
    repeat (4) step();
    check("ctl lines", {ren_i, ifc_i}, 2'h0);
    ctl_ifc_i = 1'b0;
    repeat (3) step();
    tx_data = {1'b0, GRP_LISTEN, 5'h03};
    ctl_atn_i = 1'b1;
    talk_byte(2);
    check("command", {atn_i, got_eoi, got}, {3'h0, GRP_LISTEN, 5'h03});
    ctl_atn_i = 1'b0;
    ctl_ren_i = 1'b0;
    ctl_mode_i = 1'b0;
    repeat (4) step();
    check("ctl off", {ren_oe, ifc_oe, atn_oe}, 3'h0);
    guard();
  endtask : s_ctl

  // send one command and count the device-clear pulses while it passes
  task automatic clear_cmd(input logic [6:0] c, input logic [9:0] n);
    logic [9:0] seen = '0;
    fork
      bm.send({1'b0, c}, 1'b1, 1'b0);
      for (int i = 0; i < 40; i++) begin
        step();
        seen += 10'(dev_clear_o);
      end
    join
    check("dev clear", seen, n);
  endtask : clear_cmd

  // device clear for all, selected clear only when listening, go-to-local
  task automatic s_clear();
    bm.m_ren = 1'b1;
    clear_cmd(CMD_DCL, 10'h001);
    clear_cmd(CMD_SDC, 10'h000);
    clear_cmd({GRP_LISTEN, ADDR_DEF}, 10'h000);
    check("remote", {remote_o, listen_o}, 2'h3);
    clear_cmd(CMD_SDC, 10'h001);
    clear_cmd(CMD_GTL, 10'h000);
    check("go local", {remote_o, listen_o}, 2'h1);
    bm.m_ren = 1'b0;
    clear_cmd({GRP_LISTEN, ADDR_NONE}, 10'h000);
    check("unlisten", listen_o, 1'b0);
    guard();
  endtask : s_clear

  // main sequence
  initial begin
    repeat (10) step();
    reset_n = 1'b1;
    repeat (2) step();
    s_reset();
    s_listen();
    s_talk();
    s_poll();
    s_ctl();
    s_clear();
    conclude();
  end

  // whole-run limit
  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    conclude();
  end
endmodule : gbi_port_tb_top
